// file: core/rhdsr_cfg.svh
// offsets, field positions, reset values of the root hub registers
// assumes it is included by bare name into each design file
// Function
// - descriptor B read 0x13, write 0x93
// - masked port in per-port mode follows per-port power commands only
// - global switching mode ignores the mask
// - mask bit 2 port 2, bit 1 port 1
// - removable bits per port, set means fixed
// - removable bit 2 port 2, bit 0 reserved
// - hub status read 0x14, write 0x94
// - status low half, changes high half
// - descriptor B reset values are configurable
// - overcurrent change flag, write one clears
// - bit 31 clears wake, bit 15 sets
// - bit 16 powers on unmasked ports, reads 0
// - bit 0 powers off unmasked ports, reads 0
`ifndef RHDSR_CFG_SVH
`define RHDSR_CFG_SVH
// command codes
`define RHDSR_CMD_DESCB_RD 8'h13
`define RHDSR_CMD_DESCB_WR 8'h93
`define RHDSR_CMD_STAT_RD 8'h14
`define RHDSR_CMD_STAT_WR 8'h94
// descriptor B fields, bit 0 of each field reserved
`define RHDSR_MASK_LSB 17
`define RHDSR_MASK_MSB 18
`define RHDSR_DR_LSB 1
`define RHDSR_DR_MSB 2
// hub status fields
`define RHDSR_CLR_WAKE_BIT 31
`define RHDSR_OC_CHG_BIT 17
`define RHDSR_PWR_ON_BIT 16
`define RHDSR_WAKE_BIT 15
`define RHDSR_OC_BIT 1
`define RHDSR_PWR_OFF_BIT 0
// implementation defaults for descriptor B
`define RHDSR_MASK_RST 2'h0
`define RHDSR_DR_RST 2'h0
`endif

// file: core/rhdsr_pkg.sv
// types shared by the root hub register bank
// assumes the config header is compiled alongside
package rhdsr_pkg;
    // one 32-bit register word
    typedef logic [31:0] rhdsr_word_type;
    // one bit per downstream port, ports 1 and 2
    typedef logic [2:1] rhdsr_port_type;
endpackage : rhdsr_pkg

// file: core/rhdsr_regs.sv
// root hub descriptor B and hub status registers with port power control
// assumes commands arrive as one-cycle strobes on ref_clk from the host
// interface, and that the switching mode and per-port commands come from
// neighbouring logic on the same clock; overcurrent comes from a pin
`timescale 1ns/1ns
`include "rhdsr_cfg.svh"
module rhdsr_regs
    import rhdsr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // command port from the host processor
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] wr_data,
    output logic rd_valid,
    output logic [31:0] rd_data,
    // root hub context
    input wire logic power_switch_mode_sel,
    input wire logic [2:1] port_power_set,
    input wire logic [2:1] port_power_clr,
    input wire logic overcurrent_pin,
    // state shown to the rest of the root hub
    output logic [2:1] port_power,
    output logic [2:1] port_power_mask,
    output logic [2:1] device_removable_map,
    output logic remote_wake_enable,
    output logic overcurrent_flag,
    output logic overcurrent_change_flag
);

    // decoded command strobes
    logic descb_rd;
    logic descb_wr;
    logic stat_rd;
    logic stat_wr;
    // overcurrent synchroniser stages
    logic oc_meta;
    logic oc_sync;
    logic next_oc_meta;
    logic next_oc_sync;
    // register next values
    logic [2:1] next_mask;
    logic [2:1] next_dr;
    logic next_wake;
    logic next_oci;
    logic next_occ;
    logic next_rd_valid;
    rhdsr_word_type next_rd_data;
    rhdsr_port_type next_power;
    // which ports a global command reaches
    rhdsr_port_type global_reach;
    logic oc_edge;
    logic glob_on;
    logic glob_off;

    // one command code against the strobe
    function automatic logic cmd_is(input logic [7:0] code,
                                    input logic [7:0] want);
        cmd_is = (code == want);
    endfunction : cmd_is

    // packs descriptor B, reserved and port 0 slots read zero
    function automatic rhdsr_word_type descb_word(input logic [2:1] m,
                                                  input logic [2:1] d);
        descb_word = 32'h0;
        descb_word[`RHDSR_MASK_MSB:`RHDSR_MASK_LSB] = m;
        descb_word[`RHDSR_DR_MSB:`RHDSR_DR_LSB] = d;
    endfunction : descb_word

    // packs hub status; local power bits always read zero
    function automatic rhdsr_word_type stat_word(input logic w,
                                                 input logic o,
                                                 input logic c);
        stat_word = 32'h0;
        stat_word[`RHDSR_OC_CHG_BIT] = c;
        stat_word[`RHDSR_WAKE_BIT] = w;
        stat_word[`RHDSR_OC_BIT] = o;
    endfunction : stat_word

    // command decode, same clock so no synchroniser needed
    assign descb_rd = cmd_valid && cmd_is(cmd_code, `RHDSR_CMD_DESCB_RD);
    assign descb_wr = cmd_valid && cmd_is(cmd_code, `RHDSR_CMD_DESCB_WR);
    assign stat_rd = cmd_valid && cmd_is(cmd_code, `RHDSR_CMD_STAT_RD);
    assign stat_wr = cmd_valid && cmd_is(cmd_code, `RHDSR_CMD_STAT_WR);

    // global power commands, off wins when both bits are written
    assign glob_on = stat_wr && wr_data[`RHDSR_PWR_ON_BIT];
    assign glob_off = stat_wr && wr_data[`RHDSR_PWR_OFF_BIT];
    // mask is meaningless in global switching mode
    assign global_reach = power_switch_mode_sel ?
                          ~port_power_mask : 2'h3;
    // change seen between the synchronised level and the held flag
    assign oc_edge = (oc_sync != overcurrent_flag);

    // next values of the synchroniser and status registers
    always_comb
    begin
        next_oc_meta = overcurrent_pin;
        next_oc_sync = oc_meta;
        next_oci = oc_sync;
        // descriptor B keeps only the port slots
        next_mask = port_power_mask;
        next_dr = device_removable_map;
        if (descb_wr)
        begin
            next_mask = wr_data[`RHDSR_MASK_MSB:`RHDSR_MASK_LSB];
            next_dr = wr_data[`RHDSR_DR_MSB:`RHDSR_DR_LSB];
        end
        // clear before set: a write of both bits leaves wake enabled
        next_wake = remote_wake_enable;
        if (stat_wr && wr_data[`RHDSR_CLR_WAKE_BIT])
        begin
            next_wake = 1'b0;
        end
        if (stat_wr && wr_data[`RHDSR_WAKE_BIT])
        begin
            next_wake = 1'b1;
        end
        // write-one clear first, then a new change wins over it
        next_occ = overcurrent_change_flag;
        if (stat_wr && wr_data[`RHDSR_OC_CHG_BIT])
        begin
            next_occ = 1'b0;
        end
        if (oc_edge)
        begin
            next_occ = 1'b1;
        end
        // read answer, registered one cycle after the strobe
        next_rd_valid = descb_rd || stat_rd;
        next_rd_data = rd_data;
        if (descb_rd)
        begin
            next_rd_data = descb_word(port_power_mask,
                                      device_removable_map);
        end
        else if (stat_rd)
        begin
            next_rd_data = stat_word(remote_wake_enable, overcurrent_flag,
                                     overcurrent_change_flag);
        end
    end

    // per-port power, one copy of the logic for each port
    genvar gp;
    generate
        for (gp = 1; gp <= 2; gp++)
        begin : g_port
            // masked ports in per-port mode answer only own commands
            logic own_cmd;
            assign own_cmd = power_switch_mode_sel && port_power_mask[gp];
            always_comb
            begin
                next_power[gp] = port_power[gp];
                if (own_cmd && port_power_set[gp])
                begin
                    next_power[gp] = 1'b1;
                end
                if (own_cmd && port_power_clr[gp])
                begin
                    next_power[gp] = 1'b0;
                end
                if (global_reach[gp] && glob_on)
                begin
                    next_power[gp] = 1'b1;
                end
                if (global_reach[gp] && glob_off)
                begin
                    next_power[gp] = 1'b0;
                end
            end
            // a masked port in per-port mode ignores global commands
            a_mask_hold: assert property (
                @(posedge ref_clk) disable iff (!rst_n)
                own_cmd && !port_power_set[gp] && !port_power_clr[gp]
                |=> port_power[gp] == $past(port_power[gp]))
                else $error("masked port moved on global command");
        end
    endgenerate

    // registers only; descriptor B defaults come from the config header
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oc_meta <= 1'b0;
            oc_sync <= 1'b0;
            overcurrent_flag <= 1'b0;
            overcurrent_change_flag <= 1'b0;
            remote_wake_enable <= 1'b0;
            port_power_mask <= `RHDSR_MASK_RST;
            device_removable_map <= `RHDSR_DR_RST;
            port_power <= 2'h0;
            rd_valid <= 1'b0;
            rd_data <= 32'h0;
        end
        else
        begin
            oc_meta <= next_oc_meta;
            oc_sync <= next_oc_sync;
            overcurrent_flag <= next_oci;
            overcurrent_change_flag <= next_occ;
            remote_wake_enable <= next_wake;
            port_power_mask <= next_mask;
            device_removable_map <= next_dr;
            port_power <= next_power;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end

    // checks on the answers and side effects
    a_descb_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        descb_rd |=> rd_valid && rd_data == {13'h0,
        $past(port_power_mask), 14'h0, $past(device_removable_map),
        1'b0})
        else $error("descriptor read answer wrong");
    a_descb_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        descb_wr |=> port_power_mask == $past(wr_data[18:17]) &&
        device_removable_map == $past(wr_data[2:1]))
        else $error("descriptor write not stored");
    a_stat_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stat_rd |=> rd_valid && rd_data[17] == $past(overcurrent_change_flag)
        && rd_data[15] == $past(remote_wake_enable)
        && rd_data[1] == $past(overcurrent_flag))
        else $error("hub status read answer wrong");
    a_rsvd_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_valid |-> rd_data[31:19] == 13'h0 && rd_data[16] == 1'b0
        && rd_data[14:3] == 12'h0 && rd_data[0] == 1'b0)
        else $error("reserved bits read nonzero");
    // flag follows one edge after the synchronised level moves
    a_occ_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $changed(oc_sync) |=> overcurrent_change_flag)
        else $error("overcurrent change not flagged");
    a_occ_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stat_wr && wr_data[17] && !oc_edge |=>
        !overcurrent_change_flag)
        else $error("overcurrent change not cleared");
    a_wake_ctrl: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stat_wr && (wr_data[31] || wr_data[15]) |=>
        remote_wake_enable == $past(wr_data[15]))
        else $error("remote wake enable wrong");
    a_glob_power: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !power_switch_mode_sel && stat_wr && (wr_data[16] || wr_data[0])
        |=> port_power == {2{!$past(wr_data[0])}})
        else $error("global power command missed");

endmodule : rhdsr_regs

// file: testbench/tb_top.sv
// self-checking bench for the root hub descriptor b and hub status bank
// assumes the design's config header and package are compiled first
`timescale 1ns/1ns
`include "rhdsr_cfg.svh"
module tb_top
    import rhdsr_pkg::*;
;
    // clock, reset and command port
    logic ref_clk;
    logic rst_n;
    logic cmd_valid;
    logic [7:0] cmd_code;
    rhdsr_word_type wr_data;
    logic rd_valid;
    rhdsr_word_type rd_data;
    // root hub context and state outputs
    logic power_switch_mode_sel;
    rhdsr_port_type port_power_set;
    rhdsr_port_type port_power_clr;
    logic overcurrent_pin;
    rhdsr_port_type port_power;
    rhdsr_port_type port_power_mask;
    rhdsr_port_type device_removable_map;
    logic remote_wake_enable;
    logic overcurrent_flag;
    logic overcurrent_change_flag;
    // score keeping
    int bad_count;
    int tests_run;

    rhdsr_regs i_rhdsr_regs (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data),
        .power_switch_mode_sel(power_switch_mode_sel),
        .port_power_set(port_power_set), .port_power_clr(port_power_clr),
        .overcurrent_pin(overcurrent_pin), .port_power(port_power),
        .port_power_mask(port_power_mask),
        .device_removable_map(device_removable_map),
        .remote_wake_enable(remote_wake_enable),
        .overcurrent_flag(overcurrent_flag),
        .overcurrent_change_flag(overcurrent_change_flag));

    // free-running 100 mhz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // compare with case equality so unknowns never match
    task check(input string what, input rhdsr_word_type seen,
               input rhdsr_word_type exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one-cycle command strobe; returns just after the taking edge
    task send(input logic [7:0] code, input rhdsr_word_type data);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        wr_data <= data;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
    endtask : send

    // read: answer just after the taking edge, gone after the next edge
    task read_reg(input logic [7:0] code, input string what,
                  input rhdsr_word_type exp);
        send(code, 32'h00000000);
        check("rd_valid high", {31'h0, rd_valid}, 32'h1);
        check(what, rd_data, exp);
        @(posedge ref_clk);
        #1;
        check("rd_valid low", {31'h0, rd_valid}, 32'h0);
    endtask : read_reg

    // one-cycle per-port power command pulses
    task pulse(input rhdsr_port_type s, input rhdsr_port_type c);
        @(posedge ref_clk);
        port_power_set <= s;
        port_power_clr <= c;
        @(posedge ref_clk);
        port_power_set <= 2'h0;
        port_power_clr <= 2'h0;
        #1;
    endtask : pulse

    // port power state as a word for the compare task
    function automatic rhdsr_word_type pw();
        return {30'h00000000, port_power};
    endfunction : pw

    // single exit point of the run
    task print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        bad_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        wr_data = 32'h00000000;
        power_switch_mode_sel = 1'b0;
        port_power_set = 2'h0;
        port_power_clr = 2'h0;
        overcurrent_pin = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        // defaults after reset
        read_reg(`RHDSR_CMD_DESCB_RD, "descb reset", 32'h00000000);
        read_reg(`RHDSR_CMD_STAT_RD, "status reset", 32'h00000000);
        $display("test reset values done");
        // all ones: only mask 18:17 and removable 2:1 stick
        send(`RHDSR_CMD_DESCB_WR, 32'hffffffff);
        read_reg(`RHDSR_CMD_DESCB_RD, "descb ones", 32'h00060006);
        check("removable", {30'h0, device_removable_map}, 32'h3);
        // port 2 masked, port 1 device fixed
        send(`RHDSR_CMD_DESCB_WR, 32'h00040002);
        read_reg(`RHDSR_CMD_DESCB_RD, "descb split", 32'h00040002);
        check("mask", {30'h0, port_power_mask}, 32'h2);
        check("removable p1", {30'h0, device_removable_map}, 32'h1);
        $display("test descriptor fields done");
        // global mode: mask ignored, per-port commands ignored
        send(`RHDSR_CMD_STAT_WR, 32'h00010000);
        check("global on", pw(), 32'h3);
        pulse(2'h0, 2'h3);
        check("per-port in global", pw(), 32'h3);
        read_reg(`RHDSR_CMD_STAT_RD, "power bits read", 32'h0);
        send(`RHDSR_CMD_STAT_WR, 32'h00000001);
        check("global off", pw(), 32'h0);
        $display("test global switching done");
        // per-port mode: port 2 masked, port 1 on the global switch
        @(posedge ref_clk);
        power_switch_mode_sel <= 1'b1;
        send(`RHDSR_CMD_STAT_WR, 32'h00010000);
        check("pp global on", pw(), 32'h1);
        // unmasked port ignores its own per-port clear
        pulse(2'h0, 2'h1);
        check("pp unmasked clr", pw(), 32'h1);
        pulse(2'h3, 2'h0);
        check("pp set", pw(), 32'h3);
        send(`RHDSR_CMD_STAT_WR, 32'h00000001);
        check("pp global off", pw(), 32'h2);
        pulse(2'h0, 2'h3);
        check("pp clear", pw(), 32'h0);
        $display("test per-port switching done");
        // wake enable set by bit 15, cleared by bit 31
        send(`RHDSR_CMD_STAT_WR, 32'h00008000);
        check("wake out", {31'h0, remote_wake_enable}, 32'h1);
        read_reg(`RHDSR_CMD_STAT_RD, "wake set", 32'h00008000);
        send(`RHDSR_CMD_STAT_WR, 32'h80000000);
        read_reg(`RHDSR_CMD_STAT_RD, "wake clear", 32'h00000000);
        // both bits written together: set wins
        send(`RHDSR_CMD_STAT_WR, 32'h80008000);
        check("wake both", {31'h0, remote_wake_enable}, 32'h1);
        send(`RHDSR_CMD_STAT_WR, 32'h80000000);
        check("wake off", {31'h0, remote_wake_enable}, 32'h0);
        $display("test wake enable done");
        // overcurrent and its sticky change flag
        @(posedge ref_clk);
        overcurrent_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        read_reg(`RHDSR_CMD_STAT_RD, "oc rise", 32'h00020002);
        check("oc flag", {31'h0, overcurrent_flag}, 32'h1);
        check("oc change", {31'h0, overcurrent_change_flag}, 32'h1);
        send(`RHDSR_CMD_STAT_WR, 32'h00000000);
        read_reg(`RHDSR_CMD_STAT_RD, "oc write 0", 32'h00020002);
        send(`RHDSR_CMD_STAT_WR, 32'h00020000);
        read_reg(`RHDSR_CMD_STAT_RD, "oc cleared", 32'h00000002);
        check("oc chg off", {31'h0, overcurrent_change_flag}, 32'h0);
        @(posedge ref_clk);
        overcurrent_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        read_reg(`RHDSR_CMD_STAT_RD, "oc fall", 32'h00020000);
        $display("test overcurrent done");
        // unknown code gets no answer
        send(8'h15, 32'h00000000);
        check("no answer", {31'h0, rd_valid}, 32'h0);
        $display("test unknown code done");
        print_verdict();
    end
endmodule : tb_top
